// ===== rtl/pmu_dac_defs.svh
// offsets, field positions, reset values and fixed codes of the dac register bank
`ifndef PMU_DAC_DEFS_SVH
`define PMU_DAC_DEFS_SVH
// ----------------------------------------
// wishbone register byte offsets
// ----------------------------------------
`define REG_CTRL_OFS 8'h00
`define REG_CLAMP_OFS 8'h04
`define REG_CORR_OFS 8'h08
`define REG_STATUS_OFS 8'h0c
// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define CTRL_FORCE_CURRENT_BIT 0
`define CTRL_VIEW_LSB 1
`define CTRL_RESET 3'h0
`define DAC_RESET 16'h0000
// ----------------------------------------
// command codes
// ----------------------------------------
`define DAC_OFFSET 3'h0
`define DAC_FORCE 3'h1
`define DAC_CLAMP_LOW 3'h2
`define DAC_CLAMP_HIGH 3'h3
`define DAC_COMPARE_LOW 3'h4
`define DAC_COMPARE_HIGH 3'h5
`define RANGE_EXTERNAL 3'h4
`define RANGE_VOLTAGE 3'h5
`define KIND_GAIN 2'h1
`define KIND_OFFSET 2'h2
`define KIND_INPUT 2'h3
`define SLOT_COMPARE_LOW 5'h06
`define SLOT_COMPARE_HIGH 5'h0c
`define SLOT_CLAMP_LOW_I 5'h12
`define SLOT_CLAMP_LOW_V 5'h13
`define SLOT_CLAMP_HIGH_I 5'h14
`define SLOT_CLAMP_HIGH_V 5'h15
`define CORR_MIDSCALE 16'h8000
`endif

// ===== rtl/pmu_dac_pkg.sv
// types shared by the dac register bank
package pmu_dac_pkg;
  localparam int CMD_W = 29;
  localparam int WORD_W = 24;
  localparam int SLOTS = 22;
  typedef struct packed {
    logic rd;
    logic [3:0] channel_select;
    logic [1:0] register_kind;
    logic [2:0] dac_select_field;
    logic [2:0] range_set_field;
    logic [15:0] data;
  } cmd_t;
  typedef enum logic {LINK_IDLE, LINK_FRAME} link_state_t;
endpackage

// ===== rtl/pmu_dac_bank.sv
// serial dac register bank with readback, steered and observed over wishbone
//
// What this block does
// - Separate gain, offset, input sets per range for force and compare; two clamp sets.
// - Corrected code recomputes only on input-code writes, never on coefficient writes.
// - One offset dac shared by all channels, reached with any channel bit.
// - Offset dac holds only an input code, written with register kind 11.
// - Dac select and range set decode as listed; other codes are reserved.
// - Dac read commands use the same select and range encoding.
// - Forcing voltage feeds the current clamp set to the clamp dac.
// - Forcing current feeds the voltage clamp set to the clamp dac.
// - Every register reads back over the serial link, whatever its electrical form.
// - Read: bit 28 high; channel and register kind choose the returned register.
// - Read loads 24-bit word into top of 29-bit shifter, low five bits zero.
// - Readback shifts out on rising serial clock edges inside the frame.
// - The five trailing zeros become the top bits of a 24-bit command.
// - A following 29-bit command returns the word msb first, then five zeros.
// - Write target comes from channel bits 27..24 and register kind 23..22.
// - A write lands in every channel whose select bit is set.
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "pmu_dac_defs.svh"
module pmu_dac_bank #(
  parameter int CHANNELS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic sclk_i,
  input wire logic sync_n_i,
  input wire logic sdi_i,
  output logic sdo_o
);
  if (CHANNELS != 4) begin : g_bad_channels
    $error("channel select field is four bits wide");
  end

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // slot of a dac/range pair; bit 5 flags a valid pair
  function automatic logic [5:0] slot_of(input logic [2:0] dac, input logic [2:0] rng);
    logic [4:0] base;
    logic ok;
    base = 5'h00;
    ok = 1'b0;
    unique case (dac)
      `DAC_FORCE: begin ok = (rng <= `RANGE_VOLTAGE); base = 5'h00; end
      `DAC_COMPARE_LOW: begin ok = (rng <= `RANGE_VOLTAGE); base = `SLOT_COMPARE_LOW; end
      `DAC_COMPARE_HIGH: begin ok = (rng <= `RANGE_VOLTAGE); base = `SLOT_COMPARE_HIGH; end
      `DAC_CLAMP_LOW: begin
        ok = (rng == `RANGE_EXTERNAL) || (rng == `RANGE_VOLTAGE);
        base = (rng == `RANGE_VOLTAGE) ? `SLOT_CLAMP_LOW_V : `SLOT_CLAMP_LOW_I;
      end
      `DAC_CLAMP_HIGH: begin
        ok = (rng == `RANGE_EXTERNAL) || (rng == `RANGE_VOLTAGE);
        base = (rng == `RANGE_VOLTAGE) ? `SLOT_CLAMP_HIGH_V : `SLOT_CLAMP_HIGH_I;
      end
      default: ok = 1'b0;
    endcase
    if (ok && base < `SLOT_CLAMP_LOW_I) begin
      base = base + {2'h0, rng};
    end
    return {ok, base};
  endfunction

  // corrected = input * (gain + 1) / 2^16 + offset - midscale
  function automatic logic [15:0] correct(input logic [15:0] x, input logic [15:0] m,
                                          input logic [15:0] c);
    logic [32:0] prod;
    prod = {17'h0, x} * ({17'h0, m} + 33'h1);
    return prod[31:16] + c - `CORR_MIDSCALE;
  endfunction

  function automatic logic one_hot4(input logic [3:0] v);
    return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction

  function automatic logic [1:0] chan_idx(input logic [3:0] v);
    return v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
  endfunction

  // ----------------------------------------
  // link input synchronisers
  // ----------------------------------------
  logic [1:0] sclk_s_r, sync_s_r, sdi_s_r;
  logic sclk_d_r, sync_d_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_s_r <= 2'h0;
      sync_s_r <= 2'h3;
      sdi_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
      sync_d_r <= 1'b1;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk_i};
      sync_s_r <= {sync_s_r[0], sync_n_i};
      sdi_s_r <= {sdi_s_r[0], sdi_i};
      sclk_d_r <= sclk_s_r[1];
      sync_d_r <= sync_s_r[1];
    end
  end
  logic sclk_rise, frame_start, frame_end;
  assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  assign frame_start = sync_d_r & ~sync_s_r[1];
  assign frame_end = ~sync_d_r & sync_s_r[1];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // index 0 gain, 1 offset, 2 input code, per channel and slot
  logic [15:0] mem_r [CHANNELS][3][pmu_dac_pkg::SLOTS];
  logic [15:0] offset_dac_r;
  logic [15:0] corr_r, recalc_cnt_r;

  // ----------------------------------------
  // frame handling and shift register
  // ----------------------------------------
  pmu_dac_pkg::link_state_t state_r;
  logic [pmu_dac_pkg::CMD_W-1:0] shreg_r;
  pmu_dac_pkg::cmd_t cmd;
  logic [5:0] cslot;
  logic [1:0] kidx;
  logic is_offset_dac, is_write, wr_dac;
  assign cmd = pmu_dac_pkg::cmd_t'(shreg_r);
  assign cslot = slot_of(cmd.dac_select_field, cmd.range_set_field);
  assign kidx = cmd.register_kind - 2'h1;
  assign is_offset_dac = (cmd.dac_select_field == `DAC_OFFSET) &&
                         (cmd.range_set_field == 3'h0);
  // a 24-bit flush lands with channel bits zero and so changes nothing here
  assign is_write = frame_end && (state_r == pmu_dac_pkg::LINK_FRAME) && !cmd.rd;
  assign wr_dac = is_write && (cmd.channel_select != 4'h0) && (cmd.register_kind != 2'h0);

  // readback word for a read command held in the shifter
  logic [pmu_dac_pkg::WORD_W-1:0] rb_word;
  logic [1:0] rch;
  always_comb begin
    rb_word = '0;
    rch = chan_idx(cmd.channel_select);
    if (one_hot4(cmd.channel_select) && cmd.register_kind != 2'h0) begin
      if (is_offset_dac && cmd.register_kind == `KIND_INPUT) begin
        rb_word = {cmd.register_kind, cmd.dac_select_field, cmd.range_set_field, offset_dac_r};
      end else if (cslot[5]) begin
        rb_word = {cmd.register_kind, cmd.dac_select_field, cmd.range_set_field,
                   mem_r[rch][kidx][cslot[4:0]]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= pmu_dac_pkg::LINK_IDLE;
      shreg_r <= '0;
      sdo_o <= 1'b0;
    end else begin
      unique case (state_r)
        pmu_dac_pkg::LINK_IDLE: begin
          if (frame_start) begin
            state_r <= pmu_dac_pkg::LINK_FRAME;
            sdo_o <= shreg_r[pmu_dac_pkg::CMD_W-1];
          end
        end
        pmu_dac_pkg::LINK_FRAME: begin
          if (frame_end) begin
            state_r <= pmu_dac_pkg::LINK_IDLE;
            if (cmd.rd) begin
              shreg_r <= {rb_word, 5'h00};
            end
          end else if (sclk_rise) begin
            // next bit leaves as the incoming bit enters at the bottom
            sdo_o <= shreg_r[pmu_dac_pkg::CMD_W-2];
            shreg_r <= {shreg_r[pmu_dac_pkg::CMD_W-2:0], sdi_s_r[1]};
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // dac register writes
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // cleared so readback and the clamp feed never carry unknowns
      offset_dac_r <= `DAC_RESET;
      for (int ch = 0; ch < CHANNELS; ch++) begin
        for (int kd = 0; kd < 3; kd++) begin
          for (int sl = 0; sl < pmu_dac_pkg::SLOTS; sl++) begin
            mem_r[ch][kd][sl] <= `DAC_RESET;
          end
        end
      end
    end else if (wr_dac) begin
      if (is_offset_dac) begin
        if (cmd.register_kind == `KIND_INPUT) begin
          offset_dac_r <= cmd.data;
        end
      end else if (cslot[5]) begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
          if (cmd.channel_select[ch]) begin
            mem_r[ch][kidx][cslot[4:0]] <= cmd.data;
          end
        end
      end
    end
  end

  logic recalc;
  assign recalc = wr_dac && cmd.register_kind == `KIND_INPUT && cslot[5] && !is_offset_dac;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      corr_r <= 16'h0;
      recalc_cnt_r <= 16'h0;
    end else if (recalc) begin
      // reports the lowest selected channel; coefficients are the stored ones
      corr_r <= correct(cmd.data, mem_r[chan_idx(cmd.channel_select)][0][cslot[4:0]],
                        mem_r[chan_idx(cmd.channel_select)][1][cslot[4:0]]);
      recalc_cnt_r <= recalc_cnt_r + 16'h1;
    end
  end

  // ----------------------------------------
  // clamp dac feed
  // ----------------------------------------
  logic [2:0] ctrl_r;
  logic [15:0] clamp_lo_r, clamp_hi_r;
  logic [1:0] view;
  assign view = ctrl_r[`CTRL_VIEW_LSB+:2];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clamp_lo_r <= 16'h0;
      clamp_hi_r <= 16'h0;
    end else if (ctrl_r[`CTRL_FORCE_CURRENT_BIT]) begin
      clamp_lo_r <= mem_r[view][2][`SLOT_CLAMP_LOW_V];
      clamp_hi_r <= mem_r[view][2][`SLOT_CLAMP_HIGH_V];
    end else begin
      clamp_lo_r <= mem_r[view][2][`SLOT_CLAMP_LOW_I];
      clamp_hi_r <= mem_r[view][2][`SLOT_CLAMP_HIGH_I];
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  logic wb_req;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `REG_CTRL_OFS: wb_dat_o <= {29'h0, ctrl_r};
          `REG_CLAMP_OFS: wb_dat_o <= {clamp_hi_r, clamp_lo_r};
          `REG_CORR_OFS: wb_dat_o <= {recalc_cnt_r, corr_r};
          `REG_STATUS_OFS: wb_dat_o <= {15'h0, state_r == pmu_dac_pkg::LINK_FRAME, offset_dac_r};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == `REG_CTRL_OFS && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[2:0];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_end;
    frame_end && state_r == pmu_dac_pkg::LINK_FRAME && cmd.rd;
  endsequence

  sequence s_idle_quiet;
    state_r == pmu_dac_pkg::LINK_IDLE && !frame_start;
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_answer: assert property (wb_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_read_tail_zero: assert property (s_read_end |=> shreg_r[4:0] == 5'h00)
    else $error("readback tail not zero");
  a_read_word_top: assert property (s_read_end |=> shreg_r[28:5] == $past(rb_word))
    else $error("readback word not in top bits");
  a_reserved_read: assert property (s_read_end ##0 (!cslot[5] && !is_offset_dac)
    |=> shreg_r == '0)
    else $error("reserved register read not zero");
  a_msb_first: assert property (state_r == pmu_dac_pkg::LINK_IDLE && frame_start
    |=> sdo_o == $past(shreg_r[28]))
    else $error("msb not presented at frame start");
  a_shift_rise: assert property (state_r == pmu_dac_pkg::LINK_FRAME && sclk_rise
    && !frame_end |=> sdo_o == $past(shreg_r[27]) && shreg_r[0] == $past(sdi_s_r[1]))
    else $error("shift on rising edge wrong");
  a_coef_no_recalc: assert property (is_write && cmd.register_kind != `KIND_INPUT
    |=> $stable(recalc_cnt_r) && $stable(corr_r))
    else $error("coefficient write recalculated");
  a_input_recalc: assert property (recalc |=> recalc_cnt_r == $past(recalc_cnt_r) + 16'h1)
    else $error("input write missed recalculation");
  a_clamp_current: assert property (ctrl_r[0] && $stable(ctrl_r)
    |=> clamp_lo_r == $past(mem_r[view][2][`SLOT_CLAMP_LOW_V]))
    else $error("voltage clamp set not fed");
  a_clamp_voltage: assert property (!ctrl_r[0] && $stable(ctrl_r)
    |=> clamp_hi_r == $past(mem_r[view][2][`SLOT_CLAMP_HIGH_I]))
    else $error("current clamp set not fed");
  a_offset_write: assert property (wr_dac && is_offset_dac
    && cmd.register_kind == `KIND_INPUT |=> offset_dac_r == $past(cmd.data))
    else $error("offset dac not written");
  a_frame_enter: assert property (state_r == pmu_dac_pkg::LINK_IDLE && frame_start
    |=> state_r == pmu_dac_pkg::LINK_FRAME)
    else $error("frame start not taken");
  a_sdo_idle_hold: assert property (s_idle_quiet |=> $stable(sdo_o))
    else $error("serial output moved outside a frame");
  a_flush_no_write: assert property (is_write && cmd.channel_select == 4'h0
    |=> $stable(offset_dac_r) && $stable(recalc_cnt_r))
    else $error("write with no channel changed state");
  a_read_no_write: assert property (s_read_end
    |=> $stable(offset_dac_r) && $stable(recalc_cnt_r))
    else $error("read command changed dac state");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  a_recalc_cause: assert property ($changed(recalc_cnt_r) |-> $past(recalc))
    else $error("recalculation without input write");
endmodule

// ===== tb/host_link.sv
// host side of the serial command link: frames, clocks and samples readback
`timescale 1ns/1ps
module host_link (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdi_o
);
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // outside a frame the data line carries no meaning, so keep it moving
  always @(posedge clk_i) begin
    if (sync_n_o) begin
      sdi_o <= ~sdi_o;
    end
  end
  // ----------------------------------------
  // one frame: low n bits of cmd msb first, sdo sampled just before each rise
  // ----------------------------------------
  task automatic xfer(input logic [28:0] cmd, input int n, output logic [28:0] rx);
    rx = '0;
    @(posedge clk_i);
    sync_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i);
      sclk_o <= 1'b0;
      sdi_o <= cmd[i];
      repeat (3) @(posedge clk_i);
      @(posedge clk_i);
      rx[i] = sdo_i;
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    sclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(posedge clk_i);
    sync_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the dac register bank: serial traffic and bus view
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, sclk_i, sync_n_i, sdi_i, sdo_o;
  int fails = 0;
  int total_checks = 0;
  logic [15:0] mem [int];
  logic [28:0] rx, pend;
  logic [31:0] q, c0, e;
  logic [15:0] v, g, x;
  logic [3:0] m;
  logic [1:0] k;
  logic [2:0] rs;
  bit armed = 0;
  always #50 clk_i = ~clk_i;
  pmu_dac_bank pmu_dac_bank_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sclk_i(sclk_i),
    .sync_n_i(sync_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o));
  host_link host_link_i (.clk_i(clk_i), .sdo_i(sdo_o), .sclk_o(sclk_i),
    .sync_n_o(sync_n_i), .sdi_o(sdi_i));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic int key(logic [3:0] ch, logic [1:0] k, logic [2:0] d, logic [2:0] r);
    return (d == 3'h0) ? int'({k, d, r}) : int'({ch, k, d, r});
  endfunction
  function automatic bit vld(logic [1:0] k, logic [2:0] d, logic [2:0] r);
    case (d)
      3'h0: return r == 3'h0 && k == 2'h3;
      3'h1, 3'h4, 3'h5: return r <= 3'h5 && k != 2'h0;
      3'h2, 3'h3: return (r == 3'h4 || r == 3'h5) && k != 2'h0;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [28:0] exp_rd(logic [3:0] ch, logic [1:0] k, logic [2:0] d,
      logic [2:0] r);
    int a;
    a = key(ch, k, d, r);
    if (vld(k, d, r) && $onehot(ch) && mem.exists(a)) begin
      return {k, d, r, mem[a], 5'h00};
    end
    return 29'h0;
  endfunction
  function automatic logic [3:0] pick(logic [3:0] s);
    int c;
    c = $urandom % 4;
    while (!s[c]) begin
      c = (c + 1) % 4;
    end
    return 4'h1 << c;
  endfunction
  // ----------------------------------------
  // compares, bus and link tasks
  // ----------------------------------------
  task automatic chk_ser(logic [28:0] got, logic [28:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected serial word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bus(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected bus word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      end_sim();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic bus_rd(logic [7:0] a, logic [31:0] exp);
    wb(1'b0, a, 32'h0, q);
    chk_bus(q, exp);
  endtask
  task automatic put(logic [3:0] ch, logic [1:0] k, logic [2:0] d, logic [2:0] r,
      logic [15:0] val);
    host_link_i.xfer({1'b0, ch, k, d, r, val}, 29, rx);
    if (armed) chk_ser(rx, pend);
    armed = 0;
    for (int c = 0; c < 4; c++) begin
      if (ch[c] && vld(k, d, r)) mem[key(4'h1 << c, k, d, r)] = val;
    end
  endtask
  task automatic get(logic [3:0] ch, logic [1:0] k, logic [2:0] d, logic [2:0] r);
    host_link_i.xfer({1'b1, ch, k, d, r, 16'h0}, 29, rx);
    if (armed) chk_ser(rx, pend);
    pend = exp_rd(ch, k, d, r);
    armed = 1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(42));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    bus_rd(8'h00, 32'h0);
    bus_rd(8'h10, 32'h0);
    $display("test reset done");
    for (int d = 0; d < 8; d++) begin
      for (int r = 0; r < 8; r++) begin
        m = 4'($urandom_range(15, 1));
        k = 2'($urandom_range(3, 1));
        put(m, k, 3'(d), 3'(r), 16'($urandom));
        get(pick(m), k, 3'(d), 3'(r));
      end
    end
    $display("test slots done");
    v = 16'($urandom);
    put(4'($urandom_range(15, 1)), 2'h3, 3'h0, 3'h0, v);
    bus_rd(8'h0c, {16'h0, v});
    get(pick(4'hf), 2'h3, 3'h0, 3'h0);
    get(pick(4'hf), 2'h1, 3'h0, 3'h0);
    wb(1'b0, 8'h08, 32'h0, c0);
    host_link_i.xfer(29'h0ffffff, 24, rx);
    chk_ser({rx[23:0], 5'h00}, pend);
    armed = 0;
    bus_rd(8'h08, c0);
    bus_rd(8'h0c, {16'h0, v});
    $display("test offset and flush done");
    rs = 3'($urandom_range(5, 0));
    g = 16'($urandom);
    x = 16'($urandom);
    put(4'h1, 2'h1, 3'h1, rs, g);
    put(4'h1, 2'h2, 3'h1, rs, 16'h8000);
    bus_rd(8'h08, c0);
    put(4'h1, 2'h3, 3'h1, rs, x);
    e = ((32'(x) * (32'(g) + 32'h1)) >> 16) + 32'h8000 - 32'h8000;
    bus_rd(8'h08, {c0[31:16] + 16'h1, e[15:0]});
    $display("test correction done");
    put(4'hf, 2'h3, 3'h2, 3'h4, 16'h1111);
    put(4'hf, 2'h3, 3'h3, 3'h4, 16'h2222);
    put(4'hf, 2'h3, 3'h2, 3'h5, 16'h3333);
    put(4'hf, 2'h3, 3'h3, 3'h5, 16'h4444);
    for (int f = 0; f < 2; f++) begin
      m = 4'($urandom % 4);
      wb(1'b1, 8'h00, {29'h0, m[1:0], f[0]}, q);
      bus_rd(8'h04, f ? 32'h44443333 : 32'h22221111);
    end
    wb_sel_i <= 4'he;
    wb(1'b1, 8'h00, 32'h0, q);
    wb_sel_i <= 4'hf;
    bus_rd(8'h04, 32'h44443333);
    $display("test clamp feed done");
    end_sim();
  end
endmodule
